// >>> design/tgr_reorder.v
// Notes on behaviour
// - Vantage point mirrors columns, and rows outside line-scan mode; top-left is the reset default.
// - Line-scan mode ignores height; rows simply count up without limit.
// - Column step is positive when columns rise along a row.
// - Row step is positive when rows rise at each line end.
// - Taps numbered by start row, then start column; tap 1 first.
// - Horizontal zone count is one of 1, 2, 3, 4, 8 or 10; the code handles 1, 2 and 3 only.
// - Horizontal tap count is absent or 2, 3, 4, 8, 10; the code handles absent, 2 and 3 only.
// - Extractor E reads both ends, M the middle, none the left.
// - Vertical zone count is 1 or 2; vertical tap count absent or 2.
// - Vertical E reads top and bottom lines; otherwise all on top.
// - Each tap has six values derived from width and height.
`timescale 1ns/100ps
`include "tgr_consts.vh"

module tgr_reorder (
    // Clock and reset
    input  wire                        ref_clk,
    input  wire                        rst,
    // Configuration
    input  wire [3:0]                  tap_layout_code,
    input  wire [1:0]                  vantage_point,
    input  wire                        line_scan_mode,
    input  wire [`TGR_CW-1:0]          line_pixel_count,
    input  wire [`TGR_CW-1:0]          frame_row_count,
    input  wire                        frame_start,
    // Camera taps
    input  wire                        tap_valid,
    input  wire [`TGR_PW*`TGR_TAPS-1:0] tap_data,
    // Reconstructed pixel writes
    output reg  [`TGR_TAPS-1:0]        wr_valid,
    output reg  [`TGR_PW*`TGR_TAPS-1:0] wr_data,
    output reg  [`TGR_CW*`TGR_TAPS-1:0] wr_column,
    output reg  [`TGR_CW*`TGR_TAPS-1:0] wr_row,
    output reg                         frame_done,
    output reg                         layout_error
);

////////////////////////////////////////////////////////////////////////////////
// Sync of pin inputs
reg [`TGR_PW*`TGR_TAPS-1:0] data_s1_reg;
reg [`TGR_PW*`TGR_TAPS-1:0] data_s2_reg;
reg [1:0]                   valid_s_reg;
reg [1:0]                   start_s_reg;

always @(posedge ref_clk) begin
    if (rst) begin
        data_s1_reg <= {(`TGR_PW*`TGR_TAPS){1'b0}};
        data_s2_reg <= {(`TGR_PW*`TGR_TAPS){1'b0}};
        valid_s_reg <= 2'h0;
        start_s_reg <= 2'h0;
    end else begin
        data_s1_reg <= tap_data;
        data_s2_reg <= data_s1_reg;
        valid_s_reg <= {valid_s_reg[0], tap_valid};
        start_s_reg <= {start_s_reg[0], frame_start};
    end
end

wire pix_ok = valid_s_reg[1];
wire fs_ok  = start_s_reg[1];

////////////////////////////////////////////////////////////////////////////////
// Per-tap geometry table
reg [`TGR_CW-1:0] w2;
reg [`TGR_CW-1:0] w3;
reg [`TGR_CW-1:0] h2;
reg [`TGR_CW-1:0] w_lim;
reg [`TGR_CW-1:0] h_lim;
reg [`TGR_CW*`TGR_TAPS-1:0] xs;
reg [`TGR_CW*`TGR_TAPS-1:0] xe;
reg [`TGR_CW*`TGR_TAPS-1:0] ys;
reg [`TGR_CW*`TGR_TAPS-1:0] ye;
reg [3*`TGR_TAPS-1:0]       dx;
reg [3*`TGR_TAPS-1:0]       dy;
reg [1:0]                   ntap;
reg                         bad_code;

// Three-bit signed steps: -4..3
always @* begin
    w2 = line_pixel_count >> 1;
    w3 = line_pixel_count / 14'h0003;
    h2 = frame_row_count >> 1;
    w_lim = line_pixel_count;
    // Line-scan has no frame height
    // height ignored
    h_lim = line_scan_mode ? {`TGR_CW{1'b1}} : frame_row_count;
    xs = {(`TGR_CW*`TGR_TAPS){1'b0}};
    xe = {(`TGR_CW*`TGR_TAPS){1'b0}};
    ys = {`TGR_TAPS{14'h0001}};
    ye = {`TGR_TAPS{h_lim}};
    dx = {`TGR_TAPS{3'h1}};
    dy = {`TGR_TAPS{3'h1}};
    ntap = 2'h1;
    bad_code = 1'b0;
    case (tap_layout_code)
    `TGR_LAY_1X_1Y: begin
        xs[13:0] = 14'h0001;
        xe[13:0] = w_lim;
    end
    `TGR_LAY_1X2_1Y: begin
        ntap = 2'h2;
        xs[27:0] = {14'h0002, 14'h0001};
        xe[27:0] = {w_lim, w_lim - 14'h0001};
        dx[5:0] = {3'h2, 3'h2};
    end
    `TGR_LAY_2X_1Y: begin
        ntap = 2'h2;
        xs[27:0] = {w2 + 14'h0001, 14'h0001};
        xe[27:0] = {w_lim, w2};
    end
    `TGR_LAY_2XE_1Y: begin
        ntap = 2'h2;
        xs[27:0] = {w_lim, 14'h0001};
        xe[27:0] = {w2 + 14'h0001, w2};
        dx[5:0] = {3'h7, 3'h1};
    end
    `TGR_LAY_2XM_1Y: begin
        ntap = 2'h2;
        xs[27:0] = {w2 + 14'h0001, w2};
        xe[27:0] = {w_lim, 14'h0001};
        dx[5:0] = {3'h1, 3'h7};
    end
    `TGR_LAY_1X_1Y2: begin
        ntap = 2'h2;
        xs[27:0] = {14'h0001, 14'h0001};
        xe[27:0] = {w_lim, w_lim};
        ys[27:0] = {14'h0002, 14'h0001};
        ye[27:0] = {h_lim, h_lim - 14'h0001};
        dy[5:0] = {3'h2, 3'h2};
        bad_code = line_scan_mode;
    end
    `TGR_LAY_1X_2YE: begin
        ntap = 2'h2;
        xs[27:0] = {14'h0001, 14'h0001};
        xe[27:0] = {w_lim, w_lim};
        ys[27:0] = {h_lim, 14'h0001};
        ye[27:0] = {h2 + 14'h0001, h2};
        dy[5:0] = {3'h7, 3'h1};
        bad_code = line_scan_mode;
    end
    `TGR_LAY_1X3_1Y: begin
        ntap = 2'h3;
        xs = {14'h0003, 14'h0002, 14'h0001};
        xe = {w_lim, w_lim - 14'h0001, w_lim - 14'h0002};
        dx = {3'h3, 3'h3, 3'h3};
    end
    `TGR_LAY_3X_1Y: begin
        ntap = 2'h3;
        xs = {w3 + w3 + 14'h0001, w3 + 14'h0001, 14'h0001};
        xe = {w_lim, w3 + w3, w3};
    end
    default: begin
        bad_code = 1'b1;
    end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Helpers
function [`TGR_CW-1:0] tgr_step;
    input [`TGR_CW-1:0] v;
    input [2:0]         s;
    begin
        tgr_step = v + {{(`TGR_CW-3){s[2]}}, s};
    end
endfunction

function [`TGR_CW-1:0] tgr_flip;
    input [`TGR_CW-1:0] v;
    input [`TGR_CW-1:0] lim;
    input               en;
    begin
        tgr_flip = en ? (lim + 14'h0001 - v) : v;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Tap pointers
reg [`TGR_CW*`TGR_TAPS-1:0] col_reg;
reg [`TGR_CW*`TGR_TAPS-1:0] row_reg;
reg                         run_reg;
reg [`TGR_CW*`TGR_TAPS-1:0] col_next;
reg [`TGR_CW*`TGR_TAPS-1:0] row_next;
reg [`TGR_CW*`TGR_TAPS-1:0] col_out;
reg [`TGR_CW*`TGR_TAPS-1:0] row_out;
reg [`TGR_TAPS-1:0]         tap_on;
reg [`TGR_CW-1:0]           c;
reg [`TGR_CW-1:0]           r;
reg [`TGR_CW-1:0]           c_last;
reg [`TGR_CW-1:0]           r_last;
reg [2:0]                   c_inc;
reg [2:0]                   r_inc;
reg                         line_end;
reg                         tap_end;
reg                         all_end;
wire                        take_pix;
integer                     t;

// A code that turns bad mid-frame mutes the writes at once; a start
// pulse wins over a pixel in the same cycle
assign take_pix = pix_ok & run_reg & ~bad_code & ~fs_ok;

// Next pointers and flipped coordinates for every active tap
always @* begin
    col_next = col_reg;
    row_next = row_reg;
    col_out  = {(`TGR_CW*`TGR_TAPS){1'b0}};
    row_out  = {(`TGR_CW*`TGR_TAPS){1'b0}};
    tap_on   = {`TGR_TAPS{1'b0}};
    c        = {`TGR_CW{1'b0}};
    r        = {`TGR_CW{1'b0}};
    c_last   = {`TGR_CW{1'b0}};
    r_last   = {`TGR_CW{1'b0}};
    c_inc    = 3'h0;
    r_inc    = 3'h0;
    line_end = 1'b0;
    tap_end  = 1'b0;
    all_end  = 1'b1;
    for (t = 0; t < `TGR_TAPS; t = t + 1) begin
        c        = col_reg[t*`TGR_CW +: `TGR_CW];
        r        = row_reg[t*`TGR_CW +: `TGR_CW];
        c_last   = xe[t*`TGR_CW +: `TGR_CW];
        r_last   = ye[t*`TGR_CW +: `TGR_CW];
        c_inc    = dx[t*3 +: 3];
        r_inc    = dy[t*3 +: 3];
        line_end = (c == c_last);
        // Line-scan rows never end, so a line-scan frame never ends either
        tap_end  = line_end && (r == r_last) && !line_scan_mode;
        if (t < ntap) begin
            tap_on[t] = 1'b1;
            col_out[t*`TGR_CW +: `TGR_CW] =
                tgr_flip(c, w_lim, vantage_point[0]);
            row_out[t*`TGR_CW +: `TGR_CW] = line_scan_mode ? r :
                tgr_flip(r, h_lim, vantage_point[1]);
            if (line_end) begin
                col_next[t*`TGR_CW +: `TGR_CW] = xs[t*`TGR_CW +: `TGR_CW];
                row_next[t*`TGR_CW +: `TGR_CW] = tgr_step(r, r_inc);
            end else begin
                col_next[t*`TGR_CW +: `TGR_CW] = tgr_step(c, c_inc);
            end
            if (!tap_end)
                all_end = 1'b0;
        end
    end
end

always @(posedge ref_clk) begin
    if (rst) begin
        col_reg      <= {(`TGR_CW*`TGR_TAPS){1'b0}};
        row_reg      <= {(`TGR_CW*`TGR_TAPS){1'b0}};
        run_reg      <= 1'b0;
        wr_valid     <= {`TGR_TAPS{1'b0}};
        wr_data      <= {(`TGR_PW*`TGR_TAPS){1'b0}};
        wr_column    <= {(`TGR_CW*`TGR_TAPS){1'b0}};
        wr_row       <= {(`TGR_CW*`TGR_TAPS){1'b0}};
        frame_done   <= 1'b0;
        layout_error <= 1'b0;
    end else begin
        frame_done   <= 1'b0;
        wr_valid     <= {`TGR_TAPS{1'b0}};
        layout_error <= bad_code;
        if (fs_ok) begin
            col_reg <= xs;
            row_reg <= ys;
            run_reg <= ~bad_code;
        end else if (take_pix) begin
            wr_valid  <= tap_on;
            wr_data   <= data_s2_reg;
            wr_column <= col_out;
            wr_row    <= row_out;
            col_reg   <= col_next;
            row_reg   <= row_next;
            // Pixels after the last one are ignored until the next start
            if (all_end) begin
                frame_done <= 1'b1;
                run_reg    <= 1'b0;
            end
        end
    end
end

endmodule // tgr_reorder

// >>> inc/tgr_consts.vh
`ifndef TGR_CONSTS_VH
`define TGR_CONSTS_VH
// Layout codes (one to three taps)
`define TGR_LAY_1X_1Y   4'h0
`define TGR_LAY_1X2_1Y  4'h1
`define TGR_LAY_2X_1Y   4'h2
`define TGR_LAY_2XE_1Y  4'h3
`define TGR_LAY_2XM_1Y  4'h4
`define TGR_LAY_1X_1Y2  4'h5
`define TGR_LAY_1X_2YE  4'h6
`define TGR_LAY_1X3_1Y  4'h7
`define TGR_LAY_3X_1Y   4'h8
// Vantage point
`define TGR_VP_TL       2'h0
`define TGR_VP_TR       2'h1
`define TGR_VP_BL       2'h2
`define TGR_VP_BR       2'h3
// Widths
`define TGR_CW          14
`define TGR_PW          12
`define TGR_TAPS        3
`endif

// >>> sim/tb_tgr_reorder.sv
`timescale 1ns/100ps
`include "tgr_consts.vh"
module tb_tgr_reorder;
    localparam int W = 6, H = 4, M = W / 2, T = W / 3;
    localparam int XS[9][3] = '{'{1,1,1}, '{1,2,1}, '{1,M+1,1}, '{1,W,1},
        '{M,M+1,1}, '{1,1,1}, '{1,1,1}, '{1,2,3}, '{1,T+1,2*T+1}};
    localparam int XE[9][3] = '{'{W,W,W}, '{W-1,W,W}, '{M,W,W}, '{M,M+1,W},
        '{1,W,W}, '{W,W,W}, '{W,W,W}, '{W-2,W-1,W}, '{T,2*T,W}};
    localparam int DX[9][3] = '{'{1,1,1}, '{2,2,1}, '{1,1,1}, '{1,-1,1},
        '{-1,1,1}, '{1,1,1}, '{1,1,1}, '{3,3,3}, '{1,1,1}};
    logic ref_clk = 1'b0, rst = 1'b1, line_scan_mode = 1'b0;
    logic [3:0] tap_layout_code = 4'h0;
    logic [1:0] vantage_point = 2'h0;
    logic [13:0] frame_row_count = 14'(H);
    logic [13:0] line_pixel_count = 14'(W);
    logic frame_start, tap_valid, frame_done, layout_error;
    logic [2:0] wr_valid;
    logic [35:0] tap_data, wr_data;
    logic [41:0] wr_column, wr_row;
    int ec[3], er[3], dy[3], n[3];
    int ck, nt, got, done_seen, mismatches = 0, compares = 0;
    always #2 ref_clk = ~ref_clk;
    tgr_reorder tgr_reorder_i (.ref_clk(ref_clk), .rst(rst),
        .tap_layout_code(tap_layout_code), .vantage_point(vantage_point),
        .line_scan_mode(line_scan_mode),
        .line_pixel_count(line_pixel_count),
        .frame_row_count(frame_row_count), .frame_start(frame_start),
        .tap_valid(tap_valid), .tap_data(tap_data), .wr_valid(wr_valid),
        .wr_data(wr_data), .wr_column(wr_column), .wr_row(wr_row),
        .frame_done(frame_done), .layout_error(layout_error));
    tgr_camera_model tgr_camera_model_i (.ref_clk(ref_clk),
        .frame_start(frame_start), .tap_valid(tap_valid), .tap_data(tap_data));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string s, input logic [31:0] e, g);
        compares++;
        if (e !== g) begin
            mismatches++;
            $display("mismatch %s expected %0d seen %0d", s, e, g);
        end
    endtask
    function automatic int fl(input int v, m, lim);
        return m ? lim + 1 - v : v;
    endfunction
    task automatic geo(input int c);
        ck = (c > 8) ? 0 : c;
        nt = (c == 0) ? 1 : (c > 6) ? 3 : 2;
        for (int t = 0; t < 3; t++) begin
            ec[t] = XS[ck][t];
            er[t] = (c == 5 && t == 1) ? 2 : (c == 6 && t == 1) ? H : 1;
            dy[t] = (c == 5) ? 2 : (c == 6 && t == 1) ? -1 : 1;
            n[t] = 0;
        end
    endtask
    always @(negedge ref_clk) begin
        if (frame_done === 1'b1) done_seen = 1;
        for (int t = 0; t < 3; t++) if (wr_valid[t] === 1'b1) begin
            if (t >= nt) chk("unused tap", 0, 1);
            chk("column", fl(ec[t], vantage_point[0], W),
                wr_column[t*14+:14]);
            chk("row", fl(er[t], vantage_point[1], H),
                wr_row[t*14+:14]);
            chk("data", (n[t] * 4 + t) % 4096, wr_data[t*12+:12]);
            if (ec[t] == XE[ck][t]) begin
                ec[t] = XS[ck][t];
                er[t] += dy[t];
            end else ec[t] += DX[ck][t];
            n[t]++;
            got++;
        end
    end
    task automatic frame(input int c, v, l, s, bad);
        int beats;
        @(negedge ref_clk);
        tap_layout_code = 4'(c);
        vantage_point = 2'(v);
        line_scan_mode = 1'(l);
        geo(c);
        beats = W * H / nt;
        got = 0;
        done_seen = 0;
        tgr_camera_model_i.send(beats, s[0]);
        repeat (8) @(negedge ref_clk);
        chk("pixel count", bad ? 0 : beats * nt, got);
        chk("layout error", bad, layout_error);
        chk("frame done", !l && !bad, done_seen);
    endtask
    task automatic t_layouts;
        for (int c = 0; c <= 8; c++) frame(c, c % 4, 0, c % 2, 0);
    endtask
    task automatic t_line;
        frame_row_count = 14'h0001;
        frame(3, `TGR_VP_TR, 1, 0, 0);
        frame(8, `TGR_VP_TL, 1, 1, 0);
        frame_row_count = 14'(H);
    endtask
    task automatic t_refuse;
        frame(15, `TGR_VP_TL, 0, 0, 1);
        frame(6, `TGR_VP_TL, 1, 0, 1);
        frame(0, `TGR_VP_BR, 0, 1, 0);
    endtask
    task automatic results;
        if (mismatches == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        t_layouts();
        t_line();
        t_refuse();
        results();
    end
    initial begin
        #40000;
        mismatches++;
        results();
    end
endmodule // tb_tgr_reorder

// >>> sim/tgr_camera_model.sv
`timescale 1ns/100ps
module tgr_camera_model (
    input  logic        ref_clk,
    output logic        frame_start = 1'b0,
    output logic        tap_valid = 1'b0,
    output logic [35:0] tap_data = 36'h0
);
    task automatic send(input int beats, input bit slow);
        @(negedge ref_clk);
        frame_start = 1'b1;
        @(negedge ref_clk);
        frame_start = 1'b0;
        repeat (3) @(negedge ref_clk);
        for (int b = 0; b < beats; b++) begin
            tap_valid = 1'b1;
            for (int t = 0; t < 3; t++)
                tap_data[t*12 +: 12] = 12'(b * 4 + t);
            @(negedge ref_clk);
            if (slow) begin
                tap_valid = 1'b0;
                tap_data = ~tap_data;
                @(negedge ref_clk);
            end
        end
        tap_valid = 1'b0;
        // Released lanes invert so stale data never passes for fresh
        tap_data = ~tap_data;
    endtask
endmodule // tgr_camera_model

// >>> sim/tgr_reorder_assertions.sv
`timescale 1ns/100ps
`include "tgr_consts.vh"
module tgr_reorder_checker (
    // Clock and reset
    input logic                         ref_clk,
    input logic                         rst,
    // Configuration
    input logic [3:0]                   tap_layout_code,
    input logic                         line_scan_mode,
    input logic [`TGR_CW-1:0]           line_pixel_count,
    input logic [`TGR_CW-1:0]           frame_row_count,
    // Camera taps
    input logic                         tap_valid,
    // Reconstructed pixel writes
    input logic [`TGR_TAPS-1:0]         wr_valid,
    input logic [`TGR_CW*`TGR_TAPS-1:0] wr_column,
    input logic [`TGR_CW*`TGR_TAPS-1:0] wr_row,
    input logic                         frame_done,
    input logic                         layout_error
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_held; ($stable(tap_layout_code))[*4]; endsequence
    sequence s_bad; (tap_layout_code > 4'h8)[*3]; endsequence
    sequence s_good;
        (tap_layout_code <= 4'h8 && !line_scan_mode)[*3];
    endsequence
    a_pixel_latency: assert property (
        wr_valid != 3'h0 |-> $past(tap_valid, 3)) else $error("early write");
    a_unused_taps: assert property (s_held |->
        (tap_layout_code == 4'h0 ? wr_valid[2:1] == 2'h0 :
         tap_layout_code < 4'h7 ? !wr_valid[2] : 1'b1))
        else $error("write on unused tap");
    a_bad_flagged: assert property (
        s_bad |-> layout_error) else $error("bad code not flagged");
    a_good_clear: assert property (
        s_good |-> !layout_error) else $error("good code flagged");
    a_error_mute: assert property (
        layout_error[*4] |-> wr_valid == 3'h0) else $error("write on error");
    a_column_range: assert property (wr_valid[0] |->
        wr_column[13:0] != 14'h0 && wr_column[13:0] <= line_pixel_count)
        else $error("column out of range");
    a_row_range: assert property (wr_valid[0] && !line_scan_mode |->
        wr_row[13:0] != 14'h0 && wr_row[13:0] <= frame_row_count)
        else $error("row out of range");
    a_done_pulse: assert property (
        frame_done |=> !frame_done) else $error("done longer than a cycle");
endmodule // tgr_reorder_checker
bind tgr_reorder tgr_reorder_checker tgr_reorder_checker_i (
    .ref_clk(ref_clk), .rst(rst), .tap_layout_code(tap_layout_code),
    .line_scan_mode(line_scan_mode), .line_pixel_count(line_pixel_count),
    .frame_row_count(frame_row_count), .tap_valid(tap_valid),
    .wr_valid(wr_valid), .wr_column(wr_column), .wr_row(wr_row),
    .frame_done(frame_done), .layout_error(layout_error));
